// [rtl/fbsa_core.sv]
// Purpose: Synchronous access logic of a flow-through burst SRAM, common data I/O.
// Assumes: Inputs synchronous to mclk; output enable acts without the clock.
// Notes:   Access log FIFO streams read beats and writes out on a side port; entries offered while it is full are lost.
//
// What this block does
// R1 - Register all synchronous inputs on clock rise
// R2 - Three chip selects, async output enable gates drivers
// R3 - Burst order from static strap, no command
// R4 - Either address strobe may start an access
// R5 - Burst advances only on sampled advance input
// R6 - Two-bit wraparound counter from start address
// R7 - Byte written when enable and its select low
// R8 - Global write overrides, writes all four bytes
// R9 - Processor strobe ignored when primary select high
// R10 - Read starts: selects active, either strobe low
// R11 - Controller start read: far side keeps writes off
// R12 - Start latches address into register and counter
// R13 - Read data driven after that clock when enabled
// R14 - Processor start ignores write controls first cycle
// R15 - Write at next rise after processor start
// R16 - Any write tri-states data and parity lines
// R17 - Far side releases bus before driving write data
// R18 - Test port: sample on rise, shift on fall
// R19 - Both strobes low: processor strobe only
// R20 - Order strap low linear, high interleaved
// R21 - Tri-state while deselected and first cycle after
// R22 - Start loads two low address bits
// R23 - Interleaved XOR, linear add modulo four
// R24 - Flow-through: data follows the registering edge
`timescale 1ns/100ps

module fbsa_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output      logic             out_valid,
    input  wire logic             out_ready,
    output      logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign empty     = (wr_ptr_r == rd_ptr_r);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;
    assign out_data  = store[rd_ptr_r[AW-1:0]];

    always_ff @(posedge mclk) begin
        if (push) begin
            store[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            wr_ptr_r <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
            rd_ptr_r <= pop  ? rd_ptr_r + 1'b1 : rd_ptr_r;
        end
    end

endmodule : fbsa_fifo

module fbsa_core
    import fbsa_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              chip_select_primary_n,
    input  wire logic              chip_select_expand_hi,
    input  wire logic              chip_select_expand_n,
    input  wire logic              processor_addr_strobe_n,
    input  wire logic              controller_addr_strobe_n,
    input  wire logic              burst_advance_n,
    input  wire logic              global_write_n,
    input  wire logic              byte_write_enable_n,
    input  wire logic [LANES-1:0]  byte_write_select_n,
    input  wire logic              output_enable_n,
    input  wire logic              burst_order_sel,
    input  wire logic [DATA_W-1:0] dq_i,
    output      logic [DATA_W-1:0] dq_o,
    output      logic              dq_oe,
    input  wire logic [LANES-1:0]  parity_io_i,
    output      logic [LANES-1:0]  parity_io_o,
    output      logic              parity_io_oe,
    input  wire logic              test_clk,
    input  wire logic              test_mode_sel,
    input  wire logic              test_data_in,
    output      logic              test_data_out,
    output      logic              log_space,
    output      logic              log_valid,
    input  wire logic              log_ready,
    output      fbsa_log_t         log_data
);

    fbsa_word_t        mem [0:MEM_WORDS-1];

    fbsa_state_t       state_r;
    fbsa_state_t       state_nxt;
    logic [ADDR_W-1:0] cur_addr_r;
    logic [BEAT_W-1:0] start_low_r;
    logic [BEAT_W-1:0] beat_r;
    logic [BEAT_W-1:0] beat_nxt;
    logic              order_r;
    logic              desel_r;
    logic              desel_nxt;
    logic              drive_r;
    logic              drive_nxt;
    logic              tck_r;
    logic              tap_shift_r;
    logic              tdo_r;

    // Access decode, evaluated on the values present at the rising edge
    wire cs_all     = !chip_select_primary_n && chip_select_expand_hi && !chip_select_expand_n;
    wire processor_addr_strobe_n_seen  = !processor_addr_strobe_n && !chip_select_primary_n;          // R9
    wire controller_addr_strobe_n_seen  = processor_addr_strobe_n && !controller_addr_strobe_n;       // R19
    wire strobe     = processor_addr_strobe_n_seen || controller_addr_strobe_n_seen;                                      // R4
    wire start      = strobe && cs_all;                                            // R10
    wire desel      = strobe && !cs_all;
    wire in_burst   = (state_r == FBSA_ST_BURST);
    wire cont       = !strobe && in_burst;

    // Write detection per lane; global write covers every lane
    logic [LANES-1:0] lane_en;
    fbsa_word_t       wr_word;
    fbsa_word_t       old_word;

    generate
        for (genvar b = 0; b < LANES; b++) begin : g_lane
            assign lane_en[b] = !global_write_n                                    // R8
                              || (!byte_write_enable_n && !byte_write_select_n[b]); // R7
            assign wr_word.dat[b*LANE_BITS +: LANE_BITS] = lane_en[b]
                ? dq_i[b*LANE_BITS +: LANE_BITS]
                : old_word.dat[b*LANE_BITS +: LANE_BITS];
            assign wr_word.par[b] = lane_en[b] ? parity_io_i[b] : old_word.par[b];
        end
    endgenerate

    wire write_req  = (lane_en != LANES_NONE);
    // Processor-strobe start never writes; controller start may
    wire start_w    = start && controller_addr_strobe_n_seen && write_req;                             // R14
    wire cont_w     = cont && write_req;                                           // R15
    wire do_write   = start_w || cont_w;
    wire rd_cycle   = (start && !start_w) || (cont && !write_req);

    // Counter steps only on a continue cycle with advance low
    assign beat_nxt = (cont && !burst_advance_n) ? beat_r + BEAT_STEP : beat_r;    // R5

    wire [BEAT_W-1:0] burst_low = (order_r == ORDER_LINEAR)
                                ? start_low_r + beat_nxt                           // R23
                                : start_low_r ^ beat_nxt;                          // R23

    wire [ADDR_W-1:0] acc_addr = start ? addr                                      // R12
                               : {cur_addr_r[ADDR_W-1:BEAT_W], burst_low};         // R6

    assign old_word = mem[acc_addr];

    // First cycle after deselect stays tri-stated
    assign drive_nxt = rd_cycle && !desel_r;                                       // R21
    assign desel_nxt = !start && (desel || (state_r == FBSA_ST_IDLE));
    assign state_nxt = start ? FBSA_ST_BURST : (desel ? FBSA_ST_IDLE : state_r);

    // Memory write is self-timed at the edge that samples the data
    always_ff @(posedge mclk) begin
        if (do_write) begin
            mem[acc_addr] <= wr_word;                                              // R1
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r     <= FBSA_ST_IDLE;
            cur_addr_r  <= '0;
            start_low_r <= BEAT_ZERO;
            beat_r      <= BEAT_ZERO;
            desel_r     <= 1'b1;
            drive_r     <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            cur_addr_r  <= acc_addr;                                               // R1
            start_low_r <= start ? addr[BEAT_W-1:0] : start_low_r;                 // R22
            beat_r      <= start ? BEAT_ZERO : beat_nxt;
            desel_r     <= desel_nxt;
            drive_r     <= drive_nxt;                                              // R16
        end
    end

    // Strap is caught by the clock, never by the reset itself
    always_ff @(posedge mclk) begin
        order_r <= burst_order_sel;                                                // R3 R20
    end

    // Flow-through: array read straight from the address register
    assign dq_o        = mem[cur_addr_r].dat;                                      // R24
    assign parity_io_o = mem[cur_addr_r].par;                                      // R24
    // Any detected write, start or continue, drops drivers before the edge
    wire   out_en      = drive_r && !output_enable_n && !do_write;                 // R2 R13 R16
    assign dq_oe       = out_en;
    assign parity_io_oe = out_en;

    // Test port: tck sampled as an ordinary synchronous input
    wire test_rise = test_clk && !tck_r;
    wire test_fall = !test_clk && tck_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tck_r       <= 1'b0;
            tap_shift_r <= 1'b0;
            tdo_r       <= 1'b0;
        end else begin
            tck_r <= test_clk;
            if (test_rise) begin
                tap_shift_r <= test_mode_sel ? 1'b0 : test_data_in;                // R18
            end
            if (test_fall) begin
                tdo_r <= tap_shift_r;                                              // R18
            end
        end
    end

    assign test_data_out = tdo_r;

    // Access log; an entry offered while full is lost, log_space tells the source
    fbsa_log_t log_in;
    assign log_in.wr   = do_write;
    assign log_in.addr = acc_addr;
    assign log_in.word = do_write ? wr_word : old_word;

    logic [LOG_W-1:0] log_out;

    fbsa_fifo #(
        .WIDTH (LOG_W),
        .DEPTH (LOG_DEPTH)
    ) u_log (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (do_write || rd_cycle),
        .in_ready  (log_space),
        .in_data   (log_in),
        .out_valid (log_valid),
        .out_ready (log_ready),
        .out_data  (log_out)
    );

    assign log_data = fbsa_log_t'(log_out);

endmodule : fbsa_core

// [rtl/fbsa_pkg.sv]
// Purpose: Shared constants and types for the flow-through burst SRAM access logic.
// Assumes: One 125 MHz clock (mclk), synchronous active-low reset.
// Notes:   Word is 32 data bits plus 4 parity bits, one parity bit per byte lane.
package fbsa_pkg;

    localparam int ADDR_W     = 19;
    localparam int MEM_WORDS  = 2 ** ADDR_W;
    localparam int LANES      = 4;
    localparam int LANE_BITS  = 8;
    localparam int DATA_W     = LANES * LANE_BITS;
    localparam int BEAT_W     = 2;
    localparam int LOG_DEPTH  = 16;
    localparam int CLK_PERIOD_NS = 8;

    localparam logic [BEAT_W-1:0] BEAT_ZERO     = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_STEP     = 2'h1;
    localparam logic              ORDER_LINEAR  = 1'h0;
    localparam logic [LANES-1:0]  LANES_ALL     = 4'hF;
    localparam logic [LANES-1:0]  LANES_NONE    = 4'h0;

    typedef struct packed {
        logic [LANES-1:0]  par;
        logic [DATA_W-1:0] dat;
    } fbsa_word_t;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        fbsa_word_t        word;
    } fbsa_log_t;

    localparam int LOG_W = $bits(fbsa_log_t);

    typedef enum logic [1:0] {
        FBSA_ST_IDLE  = 2'h1,
        FBSA_ST_BURST = 2'h2
    } fbsa_state_t;

endpackage : fbsa_pkg

// [dv/fbsa_core_asserts.sv]
// Purpose: Port checks for fbsa_core.
// Assumes: Bound to every fbsa_core instance, one clock domain.
// Notes:   Log checks need an empty FIFO, so only a few starts arm them.
`timescale 1ns/100ps
module fbsa_core_asserts
    import fbsa_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              chip_select_primary_n,
    input wire logic              chip_select_expand_hi,
    input wire logic              chip_select_expand_n,
    input wire logic              processor_addr_strobe_n,
    input wire logic              controller_addr_strobe_n,
    input wire logic              global_write_n,
    input wire logic              byte_write_enable_n,
    input wire logic              output_enable_n,
    input wire logic [DATA_W-1:0] dq_i,
    input wire logic              dq_oe,
    input wire logic              parity_io_oe,
    input wire logic              test_clk,
    input wire logic              test_mode_sel,
    input wire logic              test_data_in,
    input wire logic              test_data_out,
    input wire logic              log_space,
    input wire logic              log_valid,
    input wire fbsa_log_t         log_data
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    wire logic sel = !chip_select_primary_n && chip_select_expand_hi && !chip_select_expand_n;
    wire logic rd = sel && !processor_addr_strobe_n;
    wire logic pw = processor_addr_strobe_n && !controller_addr_strobe_n;
    wire logic cw = sel && pw && !global_write_n;
    wire logic desel = pw && !sel;
    wire logic wcont = processor_addr_strobe_n && controller_addr_strobe_n && !global_write_n;

    chk_oe_gate: assert property (output_enable_n |-> !dq_oe)
        else $error("data driven with output enable off");
    chk_lane_oe: assert property (parity_io_oe == dq_oe)
        else $error("parity and data enables differ");
    chk_desel_float: assert property (desel |=> !dq_oe [*2])
        else $error("driven while deselected or just after");
    chk_write_float: assert property (wcont |-> !dq_oe)
        else $error("driven during write cycle");
    chk_start_float: assert property (cw |-> !dq_oe)
        else $error("driven during controller start write");
    chk_read_log: assert property (rd && !log_valid && log_space |=>
        log_valid && !log_data.wr && log_data.addr == $past(addr))
        else $error("read start not latched");
    chk_ctrl_write: assert property (cw && !log_valid && log_space |=>
        log_valid && log_data.wr && log_data.word.dat == $past(dq_i))
        else $error("controller write not taken");
    chk_read_drive: assert property (rd ##1 rd |=>
        output_enable_n || !global_write_n || !byte_write_enable_n || dq_oe)
        else $error("read data not driven");
    chk_test_shift: assert property (($rose(test_clk) && !test_mode_sel && test_data_in)
        ##1 test_clk [*2] ##1 !test_clk |-> ##[1:2] test_data_out)
        else $error("test port bit lost");
endmodule : fbsa_core_asserts

bind fbsa_core fbsa_core_asserts fbsa_core_asserts_i (.mclk, .rst_n, .addr,
    .chip_select_primary_n, .chip_select_expand_hi, .chip_select_expand_n,
    .processor_addr_strobe_n, .controller_addr_strobe_n, .global_write_n,
    .byte_write_enable_n, .output_enable_n, .dq_i, .dq_oe, .parity_io_oe, .test_clk,
    .test_mode_sel, .test_data_in, .test_data_out, .log_space, .log_valid, .log_data);

// [dv/fbsa_host_model.sv]
// Purpose: Processor side of the shared data bus and the log consumer.
// Assumes: Bench raises wr_en in write cycles and in the ignored processor-start write (P_GW).
// Notes:   A floating bus shows a changing pattern, never a held value.
`timescale 1ns/100ps
module fbsa_host_model
    import fbsa_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic [DATA_W-1:0] dq_o,
    input  wire logic              dq_oe,
    input  wire logic              wr_en,
    input  wire logic [DATA_W-1:0] wr_dat,
    input  wire logic              stall,
    input  wire logic              log_valid,
    output      logic [DATA_W-1:0] dq_i,
    output      logic              log_ready,
    output      int                pops
);
    logic [DATA_W-1:0] last_r = '0;
    // Host drives only once the device has let go of the bus
    assign dq_i = dq_oe ? dq_o : (wr_en ? wr_dat : ~last_r);
    assign log_ready = !stall;
    always @(posedge mclk) begin
        last_r <= dq_i;
        if (log_valid && log_ready) begin
            pops <= pops + 1;
        end
    end
endmodule : fbsa_host_model

// [dv/tb_fbsa_core.sv]
// Purpose: Self-checking bench for fbsa_core.
// Assumes: Inputs change 1 ns after each rising edge, except 2 ns after the edge of the enable-gate check.
// Notes:   Control bits packed as {pstb, cstb, adv, gw, bwe, bws[3:0]}.
`timescale 1ns/100ps
module tb_fbsa_core import fbsa_pkg::*;;
    localparam logic [8:0] IDLE = 9'h1FF, P_RD = 9'h0FF, C_GW = 9'h15F, C_BW = 9'h16A;
    localparam logic [8:0] BURST_ADVANCE_N = 9'h1BF, P_GW = 9'h01F, W_ADV = 9'h19F, C_DS = 9'h17F;
    localparam logic [ADDR_W-1:0] BASE = 19'h00100;
    logic mclk = 0, rst_n = 0, oe_n = 1, ord = 0, sel_n = 0, wen = 0, stall = 0;
    logic tck = 0, tdi = 0, dq_oe, tdo, log_space, log_valid, log_ready;
    logic [LANES-1:0] par_o;
    logic [8:0] ctl = IDLE;
    logic [ADDR_W-1:0] a = '0;
    logic [DATA_W-1:0] wd = '0, dq_i, dq_o;
    logic [DATA_W-1:0] mem [int];
    fbsa_log_t log_data;
    int mismatches = 0, comparisons = 0, pops, p0;

    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

    fbsa_core fbsa_core_i (.mclk(mclk), .rst_n(rst_n), .addr(a),
        .chip_select_primary_n(sel_n), .chip_select_expand_hi(1'h1),
        .chip_select_expand_n(1'h0), .processor_addr_strobe_n(ctl[8]),
        .controller_addr_strobe_n(ctl[7]), .burst_advance_n(ctl[6]),
        .global_write_n(ctl[5]), .byte_write_enable_n(ctl[4]), .byte_write_select_n(ctl[3:0]),
        .output_enable_n(oe_n), .burst_order_sel(ord), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
        .parity_io_i(4'h5), .parity_io_o(par_o), .parity_io_oe(), .test_clk(tck),
        .test_mode_sel(1'h0), .test_data_in(tdi), .test_data_out(tdo), .log_space(log_space),
        .log_valid(log_valid), .log_ready(log_ready), .log_data(log_data));
    fbsa_host_model fbsa_host_model_i (.mclk(mclk), .dq_o(dq_o), .dq_oe(dq_oe), .wr_en(wen),
        .wr_dat(wd), .stall(stall), .log_valid(log_valid), .dq_i(dq_i),
        .log_ready(log_ready), .pops(pops));

    task automatic go(input logic [8:0] c, input logic [ADDR_W-1:0] ad,
                      input logic [DATA_W-1:0] d, input logic we);
        ctl = c;
        a = ad;
        wd = d;
        wen = we;
        @(posedge mclk);
        #1;
    endtask : go

    task automatic cmp(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        comparisons++;
        if (e !== g) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1;
        for (int i = 0; i < 4; i++) begin
            go(C_GW, BASE + i, 32'hA0B0C0D0 + i, 1);
            mem[BASE + i] = 32'hA0B0C0D0 + i;
        end
        go(C_BW, BASE, 32'h11223344, 1);
        mem[BASE] = {mem[BASE][31:24], 8'h22, mem[BASE][15:8], 8'h44};
        // Both strobes low with write controls: processor start, write ignored
        go(P_GW, BASE + 1, 32'hDEADBEEF, 1);
        go(W_ADV, BASE, 32'h55AA55AA, 1);
        mem[BASE + 2] = 32'h55AA55AA;
        $display("test writes done");
        oe_n = 0;
        for (int o = 0; o < 2; o++) begin
            ord = o[0];
            go(P_RD, BASE + 2, '0, 0);
            cmp("first beat", mem[BASE + 2], dq_o);
            cmp("first parity", 32'h5, 32'(par_o));
            for (int k = 1; k < 4; k++) begin
                go(BURST_ADVANCE_N, '0, '0, 0);
                cmp("burst beat", mem[{BASE[ADDR_W-1:2], o ? 2'h2 ^ k[1:0] : 2'h2 + k[1:0]}],
                    dq_o);
            end
        end
        $display("test bursts done");
        sel_n = 1;
        go(P_RD, BASE, '0, 0);
        cmp("ignored strobe", mem[BASE + 1], dq_o);
        go(C_DS, BASE, '0, 0);
        cmp("deselect drive", 32'h0, 32'(dq_oe));
        sel_n = 0;
        go(P_RD, BASE, '0, 0);
        cmp("first after deselect", 32'h0, 32'(dq_oe));
        go(P_RD, BASE + 1, '0, 0);
        cmp("read drive", 32'h1, 32'(dq_oe));
        cmp("read data", mem[BASE + 1], dq_o);
        oe_n = 1;
        #1;
        cmp("enable gate", 32'h0, 32'(dq_oe));
        oe_n = 0;
        $display("test drive done");
        stall = 1;
        for (int i = 0; i < LOG_DEPTH + 4; i++) begin
            go(P_RD, BASE, '0, 0);
        end
        cmp("log full", 32'h0, 32'(log_space));
        sel_n = 1;
        go(C_DS, BASE, '0, 0);
        p0 = pops;
        stall = 0;
        repeat (LOG_DEPTH + 4) @(posedge mclk);
        #1;
        cmp("log drained", 32'(LOG_DEPTH), 32'(pops - p0));
        cmp("log empty", 32'h0, 32'(log_valid));
        $display("test log done");
        for (int v = 1; v >= 0; v--) begin
            tdi = v[0];
            tck = 1;
            repeat (3) @(posedge mclk);
            #1;
            tck = 0;
            repeat (3) @(posedge mclk);
            #1;
            cmp("test out", 32'(v[0]), 32'(tdo));
        end
        $display("test port done");
        tally_and_finish();
    end

    initial begin
        #(CLK_PERIOD_NS * 2000);
        mismatches++;
        $display("mismatch watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule : tb_fbsa_core
